// ===== pkg/cwm_map.svh
// Constants for the window command mailbox: addresses, counts, status fields, timing
`ifndef CWM_MAP_SVH
`define CWM_MAP_SVH
`define CWM_PARAM_COUNT 5
`define CWM_REQ_OFFSET 16'h03E8
`define CWM_EXEC_POINT 16'h03F1
`define CWM_STATUS_EXEC_POINT 16'h03E1
`define CWM_PULSE_WINDOWS 2'h3
`define CWM_ST_READY 0
`define CWM_ST_BUSY 1
`define CWM_ST_DONE 2
`define CWM_ST_TMO 3
`define CWM_TIMEOUT_S 5
`define CWM_CLK_HZ 100000000
`define CWM_TIMEOUT_CYC (`CWM_TIMEOUT_S * `CWM_CLK_HZ)
`define CWM_WIN_MAX_CYC 64
`define CWM_CAP_DONE 2'h3
`define CWM_CAP_TAKE 2'h2
`endif

// ===== pkg/cwm_pkg.sv
// Types shared by both ends of the window command mailbox
`include "cwm_map.svh"
package cwm_pkg;
   typedef logic [15:0] cwm_word_t;
   typedef cwm_word_t [`CWM_PARAM_COUNT-1:0] cwm_params_t;
   typedef enum logic [6:0] {
      CWM_D_IDLE  = 7'h01,
      CWM_D_ID    = 7'h02,
      CWM_D_RDCMD = 7'h04,
      CWM_D_RDPAR = 7'h08,
      CWM_D_ACK   = 7'h10,
      CWM_D_STAT  = 7'h20,
      CWM_D_DONE  = 7'h40
   } cwm_dstate_t;
   typedef enum logic [2:0] {
      CWM_H_IDLE  = 3'h1,
      CWM_H_OPEN  = 3'h2,
      CWM_H_CLOSE = 3'h4
   } cwm_hstate_t;
endpackage

// ===== pkg/cwm_link_if.sv
// Backplane window link between processor end and module end
interface cwm_link_if;
   // Processor to module
   logic win_open;
   logic host_ack;
   logic [15:0] host_rdata;
   logic [15:0] cpu_id;
   logic [15:0] reg_size;
   logic [15:0] logic_size;
   // Module to processor
   logic dev_req;
   logic dev_we;
   logic dev_space;
   logic [15:0] dev_addr;
   logic [15:0] dev_wdata;
   logic dev_done;
   logic dev_fault;
   modport dev (input win_open, host_ack, host_rdata, cpu_id, reg_size, logic_size,
                output dev_req, dev_we, dev_space, dev_addr, dev_wdata, dev_done, dev_fault);
   modport cpu (output win_open, host_ack, host_rdata, cpu_id, reg_size, logic_size,
                input dev_req, dev_we, dev_space, dev_addr, dev_wdata, dev_done, dev_fault);
endinterface

// ===== hdl/cwm_dev_end.sv
// Module end of the window command mailbox
// What this block and the processor end do
// - No serial work before first window seen
// - Abort serial link after 5 s windowless
// - Request operand equals first point plus 1000
// - Fault output on only if window faulted
// - Pulse link indicator per good window
// - Command register number equals first point
// - Request operand register differs from command register
// - Zero command register after reading parameters
// - Status shows command busy and completed
// - Request mode: status at own points
// - Executive mode: status at point 993
// - Pulsed status bits last three windows
// - Executive mode when addressed at 1009
// - Executive windows continue while processor stopped
// - Processor grants windows each scan in executive mode, otherwise only on a valid request
// - Poll command between exchanges and idle
// - Zero command means no command
`include "cwm_map.svh"
module cwm_dev_end #(
   parameter int unsigned TIMEOUT_CYC = `CWM_TIMEOUT_CYC
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Backplane link
   cwm_link_if.dev lnk,
   // Address strap
   input wire logic [15:0] i_base_point,
   // Serial engine
   input wire logic i_serial_busy,
   input wire logic i_xfer_wait,
   input wire logic i_cmd_done,
   input wire logic i_serial_fault,
   output logic o_link_enable,
   output logic o_cmd_valid,
   output cwm_pkg::cwm_word_t o_cmd_num,
   output cwm_pkg::cwm_params_t o_cmd_params,
   output logic o_link_abort,
   // Indicator and host identity
   output logic o_host_link_indicator,
   output cwm_pkg::cwm_word_t o_cpu_id,
   output cwm_pkg::cwm_word_t o_reg_size,
   output cwm_pkg::cwm_word_t o_logic_size
);
   import cwm_pkg::*;

   localparam int unsigned NPULSE = 2;

   logic [15:0] bp_s1_reg, bp_s2_reg, base_reg, base_next;
   logic [1:0] cap_reg, cap_next;
   cwm_dstate_t st_reg, st_next;
   logic req_reg, req_next, we_reg, we_next, sp_reg, sp_next;
   logic [15:0] addr_reg, addr_next, wdata_reg, wdata_next;
   logic done_reg, done_next, fault_reg, fault_next;
   logic seen_reg, seen_next, busy_reg, busy_next;
   logic [2:0] pidx_reg, pidx_next;
   logic valid_reg, valid_next, ind_reg, ind_next;
   cwm_word_t num_reg, num_next, id_reg, id_next, rsz_reg, rsz_next, lsz_reg, lsz_next;
   cwm_params_t par_reg, par_next;
   logic [31:0] tmo_reg, tmo_next;
   logic abort_reg, abort_next;
   logic stat_wr;
   logic [NPULSE-1:0] pset, pbit;
   logic exec_mode;
   logic [15:0] stat_point;
   logic [7:0] stat_byte;

   // Strap passes two flops; only the second is read
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bp_s1_reg <= 16'h0000;
         bp_s2_reg <= 16'h0000;
      end else if (i_ce) begin
         bp_s1_reg <= i_base_point;
         bp_s2_reg <= bp_s1_reg;
      end
   end

   // Strap caught once, after the synchroniser has filled
   always_comb begin
      cap_next = cap_reg;
      base_next = base_reg;
      if (cap_reg != `CWM_CAP_DONE) begin
         cap_next = cap_reg + 2'h1;
      end
      if (cap_reg == `CWM_CAP_TAKE) begin
         base_next = bp_s2_reg;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cap_reg <= 2'h0;
         base_reg <= 16'h0000;
      end else if (i_ce) begin
         cap_reg <= cap_next;
         base_reg <= base_next;
      end
   end

   assign exec_mode = (base_reg == `CWM_EXEC_POINT);
   assign stat_point = exec_mode ? `CWM_STATUS_EXEC_POINT : base_reg;

   always_comb begin
      stat_byte = 8'h00;
      stat_byte[`CWM_ST_READY] = seen_reg;
      stat_byte[`CWM_ST_BUSY] = busy_reg;
      stat_byte[`CWM_ST_DONE] = pbit[0];
      stat_byte[`CWM_ST_TMO] = pbit[1];
   end

   // Window sequencer
   always_comb begin
      st_next = st_reg;
      req_next = req_reg;
      we_next = we_reg;
      sp_next = sp_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      done_next = done_reg;
      fault_next = fault_reg;
      seen_next = seen_reg;
      busy_next = busy_reg;
      pidx_next = pidx_reg;
      num_next = num_reg;
      par_next = par_reg;
      id_next = id_reg;
      rsz_next = rsz_reg;
      lsz_next = lsz_reg;
      valid_next = 1'b0;
      ind_next = 1'b0;
      stat_wr = 1'b0;
      if (i_cmd_done) begin
         busy_next = 1'b0;
      end
      if (i_serial_fault) begin
         fault_next = 1'b1;
      end
      unique case (st_reg)
         CWM_D_IDLE: begin
            if (lnk.win_open && cap_reg == `CWM_CAP_DONE) begin
               st_next = seen_reg ? CWM_D_RDCMD : CWM_D_ID;
            end
         end
         CWM_D_ID: begin
            id_next = lnk.cpu_id;
            rsz_next = lnk.reg_size;
            lsz_next = lnk.logic_size;
            seen_next = 1'b1;
            st_next = CWM_D_RDCMD;
         end
         CWM_D_RDCMD: begin
            if (i_serial_busy || busy_reg) begin
               st_next = CWM_D_STAT;
            end else if (!req_reg && !lnk.host_ack) begin
               req_next = 1'b1;
               we_next = 1'b0;
               sp_next = 1'b0;
               addr_next = base_reg;
            end else if (lnk.host_ack) begin
               req_next = 1'b0;
               pidx_next = 3'h0;
               if (lnk.host_rdata == 16'h0000) begin
                  st_next = CWM_D_STAT;
               end else begin
                  num_next = lnk.host_rdata;
                  st_next = CWM_D_RDPAR;
               end
            end
         end
         CWM_D_RDPAR: begin
            if (!req_reg && !lnk.host_ack) begin
               req_next = 1'b1;
               addr_next = base_reg + 16'h0001 + {13'h0000, pidx_reg};
            end else if (lnk.host_ack) begin
               req_next = 1'b0;
               par_next[pidx_reg] = lnk.host_rdata;
               pidx_next = pidx_reg + 3'h1;
               if (pidx_reg == 3'(`CWM_PARAM_COUNT - 1)) begin
                  st_next = CWM_D_ACK;
               end
            end
         end
         CWM_D_ACK: begin
            if (!req_reg && !lnk.host_ack) begin
               req_next = 1'b1;
               we_next = 1'b1;
               addr_next = base_reg;
               wdata_next = 16'h0000;
            end else if (lnk.host_ack) begin
               req_next = 1'b0;
               valid_next = 1'b1;
               busy_next = 1'b1;
               st_next = CWM_D_STAT;
            end
         end
         CWM_D_STAT: begin
            if (!req_reg && !lnk.host_ack) begin
               req_next = 1'b1;
               we_next = 1'b1;
               sp_next = 1'b1;
               addr_next = stat_point;
               wdata_next = {8'h00, stat_byte};
            end else if (lnk.host_ack) begin
               req_next = 1'b0;
               sp_next = 1'b0;
               stat_wr = 1'b1;
               done_next = 1'b1;
               st_next = CWM_D_DONE;
            end
         end
         CWM_D_DONE: begin
            if (!lnk.win_open) begin
               done_next = 1'b0;
               ind_next = !fault_reg;
               // Set wins: a fault in the closing cycle goes to the next window
               fault_next = i_serial_fault;
               st_next = CWM_D_IDLE;
            end
         end
      endcase
      // window gone: drop access at once
      if (!lnk.win_open && st_reg != CWM_D_IDLE && st_reg != CWM_D_DONE) begin
         req_next = 1'b0;
         done_next = 1'b0;
         fault_next = i_serial_fault;
         st_next = CWM_D_IDLE;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= CWM_D_IDLE;
         req_reg <= 1'b0;
         we_reg <= 1'b0;
         sp_reg <= 1'b0;
         addr_reg <= 16'h0000;
         wdata_reg <= 16'h0000;
         done_reg <= 1'b0;
         fault_reg <= 1'b0;
         seen_reg <= 1'b0;
         busy_reg <= 1'b0;
         pidx_reg <= 3'h0;
         num_reg <= 16'h0000;
         par_reg <= '0;
         id_reg <= 16'h0000;
         rsz_reg <= 16'h0000;
         lsz_reg <= 16'h0000;
         valid_reg <= 1'b0;
         ind_reg <= 1'b0;
      end else if (i_ce) begin
         st_reg <= st_next;
         req_reg <= req_next;
         we_reg <= we_next;
         sp_reg <= sp_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         done_reg <= done_next;
         fault_reg <= fault_next;
         seen_reg <= seen_next;
         busy_reg <= busy_next;
         pidx_reg <= pidx_next;
         num_reg <= num_next;
         par_reg <= par_next;
         id_reg <= id_next;
         rsz_reg <= rsz_next;
         lsz_reg <= lsz_next;
         valid_reg <= valid_next;
         ind_reg <= ind_next;
      end
   end

   // window wait timer, cleared by any window
   always_comb begin
      tmo_next = tmo_reg;
      abort_next = 1'b0;
      if (!i_xfer_wait || lnk.win_open) begin
         tmo_next = 32'h0000_0000;
      end else if (tmo_reg == 32'(TIMEOUT_CYC - 1)) begin
         tmo_next = 32'h0000_0000;
         abort_next = 1'b1;
      end else begin
         tmo_next = tmo_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tmo_reg <= 32'h0000_0000;
         abort_reg <= 1'b0;
      end else if (i_ce) begin
         tmo_reg <= tmo_next;
         abort_reg <= abort_next;
      end
   end

   // Pulsed status events: done and timeout
   assign pset[0] = i_cmd_done;
   assign pset[1] = abort_reg;

   // each pulsed bit shown in three status writes
   for (genvar g = 0; g < NPULSE; g++) begin : g_pulse
      logic [1:0] left_reg, left_next;
      always_comb begin
         left_next = left_reg;
         if (stat_wr && left_reg != 2'h0) begin
            left_next = left_reg - 2'h1;
         end
         // Set wins over the window countdown
         if (pset[g]) begin
            left_next = `CWM_PULSE_WINDOWS;
         end
      end
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            left_reg <= 2'h0;
         end else if (i_ce) begin
            left_reg <= left_next;
         end
      end
      assign pbit[g] = (left_reg != 2'h0);
   end

   // Link outputs, all from flops
   assign lnk.dev_req = req_reg;
   assign lnk.dev_we = we_reg;
   assign lnk.dev_space = sp_reg;
   assign lnk.dev_addr = addr_reg;
   assign lnk.dev_wdata = wdata_reg;
   assign lnk.dev_done = done_reg;
   assign lnk.dev_fault = fault_reg;
   // serial side enabled only after first window
   assign o_link_enable = seen_reg;
   assign o_cmd_valid = valid_reg;
   assign o_cmd_num = num_reg;
   assign o_cmd_params = par_reg;
   assign o_link_abort = abort_reg;
   assign o_host_link_indicator = ind_reg;
   assign o_cpu_id = id_reg;
   assign o_reg_size = rsz_reg;
   assign o_logic_size = lsz_reg;
endmodule

// ===== hdl/cwm_cpu_end.sv
// Processor end of the window command mailbox: window grant and register image
`include "cwm_map.svh"
module cwm_cpu_end #(
   parameter int unsigned REG_WORDS = 1024,
   parameter int unsigned WIN_MAX = `CWM_WIN_MAX_CYC,
   parameter logic [15:0] CPU_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] REG_SIZE = 16'h0400,
   parameter logic [15:0] LOGIC_SIZE = 16'h2000
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Backplane link
   cwm_link_if.cpu lnk,
   // Program control
   input wire logic [15:0] i_module_point,
   input wire logic i_run,
   input wire logic i_scan_tick,
   input wire logic i_req_coil,
   input wire logic [15:0] i_req_ref,
   // User register access
   input wire logic i_usr_wr,
   input wire logic [15:0] i_usr_addr,
   input wire logic [15:0] i_usr_wdata,
   output cwm_pkg::cwm_word_t o_usr_rdata,
   // Results
   output logic o_fault_coil,
   output logic o_win_refused,
   output logic [7:0] o_status_byte,
   output cwm_pkg::cwm_word_t o_status_point
);
   import cwm_pkg::*;

   localparam int IW = $clog2(REG_WORDS);

   cwm_word_t mem_reg [REG_WORDS];
   cwm_word_t mem_next [REG_WORDS];
   cwm_hstate_t st_reg, st_next;
   logic win_reg, win_next, ack_reg, ack_next, fault_reg, fault_next;
   logic ref_reg, ref_next;
   cwm_word_t rdata_reg, rdata_next, urd_reg, urd_next, spt_reg, spt_next;
   logic [7:0] sb_reg, sb_next;
   logic [7:0] cnt_reg, cnt_next;
   logic exec_mode, req_ok;
   logic [IW-1:0] didx;

   assign didx = lnk.dev_addr[IW-1:0];
   assign exec_mode = (i_module_point == `CWM_EXEC_POINT);
   assign req_ok = (mem_reg[i_req_ref[IW-1:0]] == i_module_point + `CWM_REQ_OFFSET)
                   && (i_req_ref != i_module_point);

   // Window grant and access service
   always_comb begin
      st_next = st_reg;
      win_next = win_reg;
      ack_next = 1'b0;
      fault_next = fault_reg;
      ref_next = 1'b0;
      rdata_next = rdata_reg;
      urd_next = mem_reg[i_usr_addr[IW-1:0]];
      spt_next = spt_reg;
      sb_next = sb_reg;
      cnt_next = cnt_reg;
      mem_next = mem_reg;
      unique case (st_reg)
         CWM_H_IDLE: begin
            // Program writes only outside windows
            if (i_usr_wr) begin
               mem_next[i_usr_addr[IW-1:0]] = i_usr_wdata;
            end
            if (i_scan_tick) begin
               // slot mode ignores run state; by address
               if (exec_mode || (i_run && i_req_coil && req_ok)) begin
                  win_next = 1'b1;
                  cnt_next = 8'h00;
                  st_next = CWM_H_OPEN;
               end else begin
                  ref_next = i_req_coil;
               end
            end
         end
         CWM_H_OPEN: begin
            cnt_next = cnt_reg + 8'h01;
            if (lnk.dev_req && !ack_reg) begin
               ack_next = 1'b1;
               rdata_next = mem_reg[didx];
               if (lnk.dev_we && lnk.dev_space) begin
                  sb_next = lnk.dev_wdata[7:0];
                  spt_next = lnk.dev_addr;
               end else if (lnk.dev_we) begin
                  mem_next[didx] = lnk.dev_wdata;
               end
            end
            // fault coil follows the window outcome
            if (lnk.dev_done) begin
               fault_next = lnk.dev_fault;
               win_next = 1'b0;
               st_next = CWM_H_CLOSE;
            end else if (cnt_reg == 8'(WIN_MAX - 1)) begin
               fault_next = 1'b1;
               win_next = 1'b0;
               st_next = CWM_H_CLOSE;
            end
         end
         CWM_H_CLOSE: begin
            if (!lnk.dev_done) begin
               st_next = CWM_H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= CWM_H_IDLE;
         win_reg <= 1'b0;
         ack_reg <= 1'b0;
         fault_reg <= 1'b0;
         ref_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         urd_reg <= 16'h0000;
         spt_reg <= 16'h0000;
         sb_reg <= 8'h00;
         cnt_reg <= 8'h00;
         for (int i = 0; i < REG_WORDS; i++) begin
            mem_reg[i] <= 16'h0000;
         end
      end else if (i_ce) begin
         st_reg <= st_next;
         win_reg <= win_next;
         ack_reg <= ack_next;
         fault_reg <= fault_next;
         ref_reg <= ref_next;
         rdata_reg <= rdata_next;
         urd_reg <= urd_next;
         spt_reg <= spt_next;
         sb_reg <= sb_next;
         cnt_reg <= cnt_next;
         mem_reg <= mem_next;
      end
   end

   assign lnk.win_open = win_reg;
   assign lnk.host_ack = ack_reg;
   assign lnk.host_rdata = rdata_reg;
   // Identity values are arbitrary
   assign lnk.cpu_id = CPU_ID;
   assign lnk.reg_size = REG_SIZE;
   assign lnk.logic_size = LOGIC_SIZE;
   assign o_usr_rdata = urd_reg;
   assign o_fault_coil = fault_reg;
   assign o_win_refused = ref_reg;
   assign o_status_byte = sb_reg;
   assign o_status_point = spt_reg;
endmodule

// ===== bench/cwm_link_monitor.sv
// Link checker for the window command mailbox
`include "cwm_map.svh"
module cwm_link_monitor (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Strap and link signals
   input wire logic [15:0] i_base_point,
   input wire logic i_win_open,
   input wire logic i_host_ack,
   input wire logic i_dev_req,
   input wire logic i_dev_we,
   input wire logic i_dev_space,
   input wire logic [15:0] i_dev_addr,
   input wire logic [15:0] i_dev_wdata,
   input wire logic i_dev_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] stat_pt;
   // Background slot strap moves status to 993
   assign stat_pt = (i_base_point == `CWM_EXEC_POINT) ? `CWM_STATUS_EXEC_POINT : i_base_point;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   req_in_window_a: assert property ($rose(i_dev_req) |-> i_win_open)
      else $error("access started outside window");
   // A window cut in the request cycle leaves the request unanswered
   ack_follows_a: assert property ($rose(i_dev_req) |=> (i_host_ack || !i_win_open))
      else $error("no answer one cycle after request");
   req_holds_a: assert property ((i_dev_req && !i_host_ack && i_win_open) |=>
      (i_dev_req || !i_win_open))
      else $error("request dropped before answer");
   cmd_ack_zero_a: assert property ((i_dev_req && i_dev_we && !i_dev_space) |->
      (i_dev_wdata == 16'h0000 && i_dev_addr == i_base_point))
      else $error("register write is not a zero to the command word");
   reg_read_range_a: assert property ((i_dev_req && !i_dev_we && !i_dev_space) |->
      (i_dev_addr >= i_base_point && i_dev_addr <= i_base_point + 16'(`CWM_PARAM_COUNT)))
      else $error("read outside command and parameter words");
   stat_place_a: assert property ((i_dev_req && i_dev_space) |->
      (i_dev_we && i_dev_addr == stat_pt && i_dev_wdata[15:4] == 12'h000 && i_dev_wdata[0]))
      else $error("status write misplaced or malformed");
   done_stands_a: assert property ((i_dev_done && i_win_open) |=> i_dev_done)
      else $error("done released while window open");
   win_close_a: assert property ((i_dev_done && i_win_open) |-> ##[1:2] !i_win_open)
      else $error("window not closed after done");
   win_bound_a: assert property ($rose(i_win_open) |-> ##[1:66] !i_win_open)
      else $error("window open too long");
endmodule

// ===== bench/cpu_window_command_mailbox_tb.sv
// Testbench joining both mailbox ends
module cpu_window_command_mailbox_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cwm_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] base = 16'h0009;
   logic [15:0] ref_reg = 16'h0064;
   logic [15:0] uaddr = 16'h0000;
   logic [15:0] uwd = 16'h0000;
   logic run = 1'b1, tick = 1'b0, coil = 1'b1, uwr = 1'b0;
   logic sbusy = 1'b0, xwait = 1'b0, cdone = 1'b0, sfault = 1'b0;
   logic en, cvalid, abort, ind, fcoil, refused;
   logic [7:0] sbyte;
   cwm_word_t cnum, rdata, spoint, cid, rsz, lsz;
   cwm_params_t cpar;
   int failures = 0, comparisons = 0, n_ind = 0, n_val = 0, n_abt = 0, n_ref = 0;

   cwm_link_if lnk ();
   cwm_dev_end #(.TIMEOUT_CYC(200)) i_cwm_dev_end (.i_clk(i_clk), .i_rst(i_rst),
      .i_ce(1'b1), .lnk(lnk), .i_base_point(base), .i_serial_busy(sbusy),
      .i_xfer_wait(xwait), .i_cmd_done(cdone), .i_serial_fault(sfault),
      .o_link_enable(en), .o_cmd_valid(cvalid), .o_cmd_num(cnum), .o_cmd_params(cpar),
      .o_link_abort(abort), .o_host_link_indicator(ind), .o_cpu_id(cid),
      .o_reg_size(rsz), .o_logic_size(lsz));
   cwm_cpu_end i_cwm_cpu_end (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .lnk(lnk),
      .i_module_point(base), .i_run(run), .i_scan_tick(tick), .i_req_coil(coil),
      .i_req_ref(ref_reg), .i_usr_wr(uwr), .i_usr_addr(uaddr), .i_usr_wdata(uwd),
      .o_usr_rdata(rdata), .o_fault_coil(fcoil), .o_win_refused(refused),
      .o_status_byte(sbyte), .o_status_point(spoint));
   cwm_link_monitor i_cwm_link_monitor (.i_clk(i_clk), .i_rst(i_rst), .i_base_point(base),
      .i_win_open(lnk.win_open), .i_host_ack(lnk.host_ack), .i_dev_req(lnk.dev_req),
      .i_dev_we(lnk.dev_we), .i_dev_space(lnk.dev_space), .i_dev_addr(lnk.dev_addr),
      .i_dev_wdata(lnk.dev_wdata), .i_dev_done(lnk.dev_done));

   // Free-running 100 MHz clock
   initial forever #5 i_clk = ~i_clk;

   // Pulse counters, since pulses last one cycle
   always @(posedge i_clk) begin
      n_ind += (ind === 1'b1);
      n_val += (cvalid === 1'b1);
      n_abt += (abort === 1'b1);
      n_ref += (refused === 1'b1);
   end

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         failures++;
      end
   endtask

   // Register image writes only while no window runs
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk);
      uwr <= 1'b1;
      uaddr <= a;
      uwd <= d;
      @(posedge i_clk);
      uwr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_clk);
      uaddr <= a;
      repeat (2) @(posedge i_clk);
      #1 d = rdata;
   endtask

   // One scan tick, then a bounded wait for open and full close
   task automatic win(input bit opens);
      int n;
      @(posedge i_clk);
      tick <= 1'b1;
      @(posedge i_clk);
      tick <= 1'b0;
      n = 0;
      while (opens && lnk.win_open !== 1'b1 && n < 200) begin
         @(posedge i_clk);
         n++;
      end
      while ((lnk.win_open !== 1'b0 || lnk.dev_done !== 1'b0) && n < 200) begin
         @(posedge i_clk);
         n++;
      end
      chk("window wait", 16'h0000, 16'(n >= 200));
      if (n >= 200) report_and_stop();
      repeat (3) @(posedge i_clk);
      #1;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge i_clk);
      failures++;
      $display("ERROR run length expected finish seen hang");
      report_and_stop();
   end

   initial begin
      logic [15:0] v;
      int k0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      wr(16'h0064, 16'h03F1);
      chk("link enable", 16'h0000, {15'h0, en});
      win(1'b1);
      chk("link enable", 16'h0001, {15'h0, en});
      chk("cpu id", 16'h1234, cid);
      chk("reg size", 16'h0400, rsz);
      chk("logic size", 16'h2000, lsz);
      chk("status point", 16'h0009, spoint);
      chk("status byte", 16'h0001, {8'h00, sbyte});
      chk("indicator", 16'h0001, 16'(n_ind));
      $display("Test first window done");
      // Run off, request on command word, wrong operand
      for (int k = 0; k < 3; k++) begin
         run <= (k != 0);
         ref_reg <= (k == 1) ? 16'h0009 : 16'h0064;
         if (k == 2) wr(16'h0064, 16'h03F0);
         win(1'b0);
         chk("refused", 16'(k + 1), 16'(n_ref));
      end
      wr(16'h0064, 16'h03F1);
      wr(16'h0009, 16'h0005);
      for (int k = 0; k < 5; k++) wr(16'(10 + k), 16'(16'h0011 + k));
      win(1'b1);
      chk("cmd valid", 16'h0001, 16'(n_val));
      chk("cmd num", 16'h0005, cnum);
      chk("param first", 16'h0011, cpar[0]);
      chk("param last", 16'h0015, cpar[4]);
      rd(16'h0009, v);
      chk("cmd word", 16'h0000, v);
      chk("status byte", 16'h0003, {8'h00, sbyte});
      @(posedge i_clk) cdone <= 1'b1;
      @(posedge i_clk) cdone <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         win(1'b1);
         chk("status byte", (k < 3) ? 16'h0005 : 16'h0001, {8'h00, sbyte});
      end
      $display("Test command done");
      // Zero word, then busy engine holds off the poll
      win(1'b1);
      chk("cmd valid", 16'h0001, 16'(n_val));
      sbusy <= 1'b1;
      wr(16'h0009, 16'h0007);
      win(1'b1);
      chk("cmd valid", 16'h0001, 16'(n_val));
      sbusy <= 1'b0;
      win(1'b1);
      chk("cmd valid", 16'h0002, 16'(n_val));
      chk("cmd num", 16'h0007, cnum);
      $display("Test poll done");
      k0 = n_ind;
      // Fault pulse between windows is charged to the next window
      sfault <= 1'b1;
      @(posedge i_clk) sfault <= 1'b0;
      win(1'b1);
      chk("fault coil", 16'h0001, {15'h0, fcoil});
      chk("indicator", 16'(k0), 16'(n_ind));
      win(1'b1);
      chk("fault coil", 16'h0000, {15'h0, fcoil});
      chk("indicator", 16'(k0 + 1), 16'(n_ind));
      $display("Test fault done");
      xwait <= 1'b1;
      repeat (260) @(posedge i_clk);
      chk("abort", 16'h0001, 16'(n_abt));
      xwait <= 1'b0;
      win(1'b1);
      chk("timeout bit", 16'h0001, {15'h0, sbyte[3]});
      $display("Test timeout done");
      // Restart strapped to the background slot with the processor stopped
      i_rst <= 1'b1;
      base <= 16'h03F1;
      run <= 1'b0;
      coil <= 1'b0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      k0 = n_ind;
      win(1'b1);
      chk("status point", 16'h03E1, spoint);
      chk("indicator", 16'(k0 + 1), 16'(n_ind));
      $display("Test background slot done");
      report_and_stop();
   end
endmodule
